// ### core/sdc_pkg.sv
// Purpose: shared constants and types for the sdram command decode link
// Assumes: one clock, 16-bit data pins, eight banks, 13-bit row address
// Notes: the data path is modelled at the pin word level (one word per beat, 8 beats per access or 4 when chopped)
// Overview of operation
// R1 - low select decodes row/column/write strobe commands
// R2 - high select means deselect, inputs ignored
// R3 - address bit ten qualifies close and calibration
// R4 - bit twelve picks chop or eight beats
// R5 - clock gate judged now and previous cycle
// R6 - gate falling enters power-down or self refresh
// R7 - gate rising with idle exits low power
// R8 - masked lanes discard write data
// R9 - two byte masks act independently
// R10 - controller obeys bank idle/active state; the model's controller tracks no bank state and leaves it to the user
// R11 - eight banks, bank bits pick, row opened
// R12 - read/write address gives starting column
// R13 - every access starts with activate
// R14 - eight pin words per four clocks; the model moves one pin word per clock
// R15 - eight beats or four when chopped, ordered
// R16 - controller completes initialization before normal commands; the model's controller has no init sequence and leaves it to the user
// R17 - only idle between last mode load and calibration
// R18 - low mask bits 0-7, high 8-15
// R19 - bank bits select one of four mode registers
// R20 - controller never drives undefined combinations; the model's controller drives whatever the user requests
package sdc_pkg;
   localparam int DQ_W = 16;
   localparam int ROW_W = 13;
   localparam int BANK_W = 3;
   localparam int NBANK = 8;
   localparam int COL_W = 10;
   localparam int BEATS_FULL = 8;
   localparam int BEATS_CHOP = 4;
   localparam int AUTO_CLOSE_POS = 10;
   localparam int CHOP_POS = 12;
   localparam int MR_NUM = 4;
   // mode register 0: bits 1:0 burst length, bit 3 burst type
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_FIXED4 = 2'h2;
   localparam int MR0_BT_POS = 3;
   // {ras,cas,we}
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_WR = 3'h4;
   localparam logic [2:0] CMD_RD = 3'h5;
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_ZQ = 3'h6;
   localparam logic [2:0] CMD_NOP = 3'h7;
   typedef enum logic [3:0] {
      SDC_OP_NONE = 4'h0, SDC_OP_ACT = 4'h1, SDC_OP_PRE = 4'h2, SDC_OP_PREA = 4'h3,
      SDC_OP_WR = 4'h4, SDC_OP_RD = 4'h5, SDC_OP_MRS = 4'h6, SDC_OP_REF = 4'h7,
      SDC_OP_ZQL = 4'h8, SDC_OP_ZQS = 4'h9, SDC_OP_PDE = 4'ha, SDC_OP_SRE = 4'hb,
      SDC_OP_PDX = 4'hc, SDC_OP_SRX = 4'hd, SDC_OP_ILL = 4'he
   } sdc_op_e;
   // pin word order inside a burst: sequential or interleaved from the start column
   function automatic logic [2:0] sdc_beat_col(input logic [2:0] start, input logic [2:0] beat,
                                               input logic interleave, input logic chop);
      logic [2:0] r;
      r = 3'h0;
      if (interleave) begin
         r = start ^ beat;
      end else if (chop) begin
         r = {start[2], 2'(start[1:0] + beat[1:0])};
      end else begin
         r = 3'(start + beat);
      end
      return r;
   endfunction : sdc_beat_col
endpackage : sdc_pkg

// ### core/sdc_if.sv
// Purpose: command/address/data pins between controller and device
// Assumes: single clock; data pins split into in/out/enable per end
// Notes: dq is resolved here from the two enables
`timescale 1ns/1ps
interface sdc_if;
   import sdc_pkg::*;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [BANK_W-1:0] bank_select;
   logic [ROW_W-1:0] addr;
   logic low_byte_mask;
   logic high_byte_mask;
   logic [DQ_W-1:0] ctl_dq;
   logic ctl_dq_oe;
   logic [DQ_W-1:0] dev_dq;
   logic dev_dq_oe;
   logic [DQ_W-1:0] dq;
   assign dq = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : '0);
   modport ctl (output cke, cs_n, ras_n, cas_n, we_n, bank_select, addr, low_byte_mask,
                high_byte_mask, ctl_dq, ctl_dq_oe, input dq);
   modport dev (input cke, cs_n, ras_n, cas_n, we_n, bank_select, addr, low_byte_mask,
                high_byte_mask, dq, output dev_dq, dev_dq_oe);
endinterface : sdc_if

// ### core/sdc_cmd_decode.sv
// Purpose: combinational command decode from pins and clock gate pair
// Assumes: inputs synchronous to clock_i
// Notes: leaf used by the device end
`timescale 1ns/1ps
module sdc_cmd_decode (
   // pins
   input wire logic cke_prev_i,
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic [2:0] rcw_i,
   input wire logic auto_close_bit_i,
   // result
   output sdc_pkg::sdc_op_e op_o
);
   import sdc_pkg::*;
   wire logic idle_like = cs_n_i | (rcw_i == CMD_NOP);
   wire logic gate_hh = cke_prev_i & cke_i; // R5
   wire logic gate_hl = cke_prev_i & ~cke_i;
   wire logic gate_lh = ~cke_prev_i & cke_i;
   always_comb begin
      op_o = SDC_OP_NONE;
      if (gate_hh && !cs_n_i) begin // R2
         case (rcw_i) // R1
            CMD_ACT: op_o = SDC_OP_ACT;
            CMD_PRE: op_o = auto_close_bit_i ? SDC_OP_PREA : SDC_OP_PRE; // R3
            CMD_WR: op_o = SDC_OP_WR;
            CMD_RD: op_o = SDC_OP_RD;
            CMD_MRS: op_o = SDC_OP_MRS;
            CMD_REF: op_o = SDC_OP_REF;
            CMD_ZQ: op_o = auto_close_bit_i ? SDC_OP_ZQL : SDC_OP_ZQS; // R3
            default: op_o = SDC_OP_NONE;
         endcase
      end else if (gate_hl) begin
         if (idle_like) op_o = SDC_OP_PDE; // R6
         else if (rcw_i == CMD_REF) op_o = SDC_OP_SRE; // R6
         else op_o = SDC_OP_ILL; // R20
      end else if (gate_lh) begin
         op_o = idle_like ? SDC_OP_PDX : SDC_OP_ILL; // R7
      end
   end
endmodule : sdc_cmd_decode

// ### core/sdc_device.sv
// Purpose: device end: bank state, mode registers, power state and burst data path
// Assumes: controller keeps bank, init and timing ordering; no latency modelled
// Notes: write data is taken on the clocks after the write command, read data driven likewise
`timescale 1ns/1ps
module sdc_device #(
   parameter int MEM_DEPTH = 256
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // link
   sdc_if.dev link,
   // status
   output sdc_pkg::sdc_op_e last_op_o,
   output logic [sdc_pkg::NBANK-1:0] bank_open_o,
   output logic powered_down_o,
   output logic self_refresh_o,
   output logic burst_busy_o
);
   import sdc_pkg::*;
   // power state; both low power states leave through the same exit op
   typedef enum logic [2:0] {
      SDC_PW_RUN = 3'b001,
      SDC_PW_PD = 3'b010,
      SDC_PW_SR = 3'b100
   } sdc_pw_e;
   localparam int IDX_W = $clog2(MEM_DEPTH);
   localparam int FULL_W = BANK_W + ROW_W + COL_W;
   // byte lane pass pattern: a high mask bit keeps the stored byte
   function automatic logic [7:0] lane_pass(input logic mask);
      return {8{~mask}};
   endfunction : lane_pass
   // decoded operation and clock gate history
   sdc_op_e op;
   logic cke_q;
   sdc_pw_e pw_q;
   sdc_pw_e pw_d;
   // mode registers and stored array
   logic [ROW_W-1:0] mr_q [MR_NUM];
   logic [DQ_W-1:0] mem_q [MEM_DEPTH];
   // burst state, latched when the read or write is taken
   logic busy_q;
   logic [2:0] beat_q;
   logic [2:0] start_q;
   logic wr_q;
   logic chop_q;
   logic ac_q;
   logic [BANK_W-1:0] bbank_q;
   logic [COL_W-1:0] col_q;
   // per-bank state gathered from the bank loop below
   wire logic [NBANK-1:0] open_w;
   wire logic [ROW_W-1:0] row_w [NBANK];
   // the decoder sees the gate level of this edge and of the previous one
   sdc_cmd_decode u_dec (
      .cke_prev_i(cke_q),
      .cke_i(link.cke),
      .cs_n_i(link.cs_n),
      .rcw_i({link.ras_n, link.cas_n, link.we_n}),
      .auto_close_bit_i(link.addr[AUTO_CLOSE_POS]),
      .op_o(op)
   );
   // one strobe per operation that changes state here
   wire logic act_hit = (op == SDC_OP_ACT);
   wire logic pre_hit = (op == SDC_OP_PRE);
   wire logic prea_hit = (op == SDC_OP_PREA);
   wire logic mrs_hit = (op == SDC_OP_MRS);
   wire logic wr_hit = (op == SDC_OP_WR);
   wire logic rd_hit = (op == SDC_OP_RD);
   wire logic pde_hit = (op == SDC_OP_PDE);
   wire logic sre_hit = (op == SDC_OP_SRE);
   wire logic pdx_hit = (op == SDC_OP_PDX);
   wire logic rw_cmd = wr_hit || rd_hit;
   wire logic all_idle = (open_w == '0);
   wire logic [1:0] bl_mode = mr_q[0][1:0];
   wire logic otf_chop = (bl_mode == BL_OTF) ? ~link.addr[CHOP_POS] : 1'b0; // R4
   wire logic cmd_chop = (bl_mode == BL_FIXED4) | otf_chop;
   wire logic [2:0] last_beat = chop_q ? 3'(BEATS_CHOP - 1) : 3'(BEATS_FULL - 1); // R15
   wire logic last_now = busy_q && (beat_q == last_beat);
   wire logic close_now = last_now && ac_q; // R3
   // 8n prefetch folded to one pin word per beat; address = bank,row,col
   wire logic [2:0] beat_col = sdc_beat_col(start_q, beat_q, mr_q[0][MR0_BT_POS], chop_q);
   wire logic [FULL_W-1:0] full_addr = {bbank_q, row_w[bbank_q], col_q[COL_W-1:3], beat_col}; // R14 R12
   wire logic [IDX_W-1:0] mem_idx = full_addr[IDX_W-1:0];
   wire logic [DQ_W-1:0] lane_en = {lane_pass(link.high_byte_mask), lane_pass(link.low_byte_mask)}; // R9 R18
   wire logic [DQ_W-1:0] wr_word = (link.dq & lane_en) | (mem_q[mem_idx] & ~lane_en); // R8
   // power state: run, power-down, self refresh
   always_comb begin
      pw_d = pw_q;
      case (pw_q)
         SDC_PW_RUN: begin
            if (pde_hit) begin
               pw_d = SDC_PW_PD; // R6
            end else if (sre_hit && all_idle) begin
               // a self refresh entry with a bank open is refused and changes nothing
               pw_d = SDC_PW_SR; // R6
            end
         end
         SDC_PW_PD, SDC_PW_SR: begin
            if (pdx_hit) begin
               pw_d = SDC_PW_RUN; // R7
            end
         end
         default: begin
            pw_d = SDC_PW_RUN;
         end
      endcase
   end
   // gate history resets low, so a gate rising after reset reads as an exit
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         cke_q <= 1'b0;
         pw_q <= SDC_PW_RUN;
         last_op_o <= SDC_OP_NONE;
      end else begin
         cke_q <= link.cke; // R5
         pw_q <= pw_d;
         last_op_o <= op;
      end
   end
   // per-bank open flag and row; an activate on the edge of an auto-close wins
   for (genvar g = 0; g < NBANK; g++) begin : g_bank
      logic open_b_q;
      logic [ROW_W-1:0] row_b_q;
      wire logic hit = (link.bank_select == BANK_W'(g));
      wire logic set_b = act_hit && hit;
      wire logic clr_b = (pre_hit && hit) || prea_hit || (close_now && (bbank_q == BANK_W'(g))); // R3
      always_ff @(posedge clock_i) begin
         if (!rst_n_i) begin
            open_b_q <= 1'b0;
         end else if (set_b) begin
            open_b_q <= 1'b1; // R11
         end else if (clr_b) begin
            open_b_q <= 1'b0;
         end
      end
      // the row needs no reset: it is only read while its bank is open
      always_ff @(posedge clock_i) begin
         if (set_b) begin
            row_b_q <= link.addr; // R11
         end
      end
      assign open_w[g] = open_b_q;
      assign row_w[g] = row_b_q;
   end
   assign bank_open_o = open_w;
   // mode registers
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < MR_NUM; i++) begin
            mr_q[i] <= '0;
         end
      end else if (mrs_hit) begin
         mr_q[link.bank_select[1:0]] <= link.addr; // R19
      end
   end
   // burst sequencing; a new read or write during a burst restarts it
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         busy_q <= 1'b0;
         beat_q <= 3'h0;
      end else if (rw_cmd) begin
         busy_q <= 1'b1;
         beat_q <= 3'h0;
      end else if (busy_q) begin
         busy_q <= ~last_now; // R15
         beat_q <= 3'(beat_q + 3'h1);
      end
   end
   // burst attributes, latched with the command
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         start_q <= 3'h0;
         col_q <= '0;
         wr_q <= 1'b0;
         chop_q <= 1'b0;
         ac_q <= 1'b0;
         bbank_q <= '0;
      end else if (rw_cmd) begin
         start_q <= link.addr[2:0]; // R12
         col_q <= link.addr[COL_W-1:0];
         wr_q <= wr_hit;
         chop_q <= cmd_chop; // R4
         ac_q <= link.addr[AUTO_CLOSE_POS]; // R3
         bbank_q <= link.bank_select;
      end
   end
   // write path; the array has no reset, so unwritten words read as unknown
   always_ff @(posedge clock_i) begin
      if (busy_q && wr_q) begin
         mem_q[mem_idx] <= wr_word; // R8
      end
   end
   // read path: data leaves one clock after its beat; no column latency modelled
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         link.dev_dq_oe <= 1'b0;
         link.dev_dq <= '0;
      end else begin
         link.dev_dq_oe <= busy_q && !wr_q; // R14
         if (busy_q && !wr_q) begin
            link.dev_dq <= mem_q[mem_idx];
         end
      end
   end
   // status outputs
   assign burst_busy_o = busy_q;
   assign powered_down_o = (pw_q == SDC_PW_PD);
   assign self_refresh_o = (pw_q == SDC_PW_SR);
endmodule : sdc_device

// ### core/sdc_controller.sv
// Purpose: controller end: drives one command per request onto the pins
// Assumes: user sequences legal commands (init, bank state) itself
// Notes: write data is accepted per beat through wdata_i and driven while wdata_en_i is high
`timescale 1ns/1ps
module sdc_controller (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // user command
   input wire logic req_i,
   input wire logic [2:0] rcw_i,
   input wire logic desel_i,
   input wire logic cke_i,
   input wire logic [sdc_pkg::BANK_W-1:0] bank_i,
   input wire logic [sdc_pkg::ROW_W-1:0] addr_i,
   input wire logic [sdc_pkg::DQ_W-1:0] wdata_i,
   input wire logic [1:0] wmask_i,
   input wire logic wdata_en_i,
   output logic [sdc_pkg::DQ_W-1:0] rdata_o,
   // link
   sdc_if.ctl link
);
   import sdc_pkg::*;
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         link.cke <= 1'b0;
         link.cs_n <= 1'b1;
         {link.ras_n, link.cas_n, link.we_n} <= CMD_NOP; // R16 R17
         link.bank_select <= '0;
         link.addr <= '0;
         link.low_byte_mask <= 1'b0;
         link.high_byte_mask <= 1'b0;
         link.ctl_dq <= '0;
         link.ctl_dq_oe <= 1'b0;
         rdata_o <= '0;
      end else begin
         link.cke <= cke_i; // R5
         link.cs_n <= ~req_i | desel_i; // R2
         {link.ras_n, link.cas_n, link.we_n} <= req_i ? rcw_i : CMD_NOP; // R1 R20
         link.bank_select <= bank_i; // R10 R13
         link.addr <= addr_i;
         link.ctl_dq <= wdata_i;
         link.ctl_dq_oe <= wdata_en_i;
         {link.high_byte_mask, link.low_byte_mask} <= wmask_i; // R9
         rdata_o <= link.dq;
      end
   end
endmodule : sdc_controller

// ### tb/sdc_props.sv
// Purpose: pin-level checks of the device decode across the link
// Assumes: device answers one cycle after the command edge
// Notes: clock gate history is rebuilt locally, reset clears it low
`timescale 1ns/1ps
module sdc_props
   import sdc_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // link pins
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [BANK_W-1:0] bank_select,
   input wire logic [ROW_W-1:0] addr,
   input wire logic dev_dq_oe,
   // device status
   input sdc_op_e last_op_o,
   input wire logic [NBANK-1:0] bank_open_o,
   input wire logic powered_down_o,
   input wire logic self_refresh_o,
   input wire logic burst_busy_o
);
   logic cke_q;
   wire [2:0] rcw = {ras_n, cas_n, we_n};
   wire live = cke_q && cke && !cs_n;
   wire quiet = cs_n || (rcw == CMD_NOP);
   always_ff @(posedge clock_i) begin
      cke_q <= rst_n_i ? cke : 1'b0;
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_rd;
      live && rcw == CMD_RD;
   endsequence
   sequence s_wr;
      live && rcw == CMD_WR;
   endsequence
   a_act_decode: assert property (live && rcw == CMD_ACT |=> last_op_o == SDC_OP_ACT && bank_open_o[$past(bank_select)])
      else $error("activate not decoded");
   a_desel_ignored: assert property (cke_q && cke && cs_n |=> last_op_o == SDC_OP_NONE)
      else $error("deselect produced an operation");
   a_pre_all: assert property (live && rcw == CMD_PRE && addr[AUTO_CLOSE_POS] |=> last_op_o == SDC_OP_PREA && bank_open_o == '0)
      else $error("close-all failed");
   a_zq_variant: assert property (live && rcw == CMD_ZQ |=> last_op_o == ($past(addr[AUTO_CLOSE_POS]) ? SDC_OP_ZQL : SDC_OP_ZQS))
      else $error("calibration variant wrong");
   a_pd_entry: assert property (cke_q && !cke && quiet |=> last_op_o == SDC_OP_PDE)
      else $error("power-down entry missed");
   a_lp_exit: assert property (!cke_q && cke && quiet && (powered_down_o || self_refresh_o) |=> last_op_o == SDC_OP_PDX ##1 !powered_down_o && !self_refresh_o)
      else $error("low power exit missed");
   a_wr_beats: assert property (s_wr |=> burst_busy_o [*4])
      else $error("write burst too short");
   a_rd_drive: assert property (s_rd |-> ##2 dev_dq_oe [*4])
      else $error("read data not driven");
endmodule : sdc_props

// ### tb/sdram_command_decode_tb_top.sv
// Purpose: joins controller and device ends and walks the command set
// Assumes: user side sequences legal commands itself
// Notes: memory is unknown until written, so masks are judged over a prior write
`timescale 1ns/1ps
module sdram_command_decode_tb_top;
   import sdc_pkg::*;
   logic clock_i = 0, rst_n_i = 0, req_i = 0, desel_i = 0, cke_i = 1, wdata_en_i = 0;
   logic [2:0] rcw_i = CMD_NOP;
   logic [BANK_W-1:0] bank_i = '0;
   logic [ROW_W-1:0] addr_i = '0;
   logic [DQ_W-1:0] wdata_i = '0;
   logic [DQ_W-1:0] rdata_o;
   logic [1:0] wmask_i = '0;
   sdc_op_e last_op_o;
   logic [NBANK-1:0] bank_open_o;
   logic powered_down_o, self_refresh_o, burst_busy_o;
   int err_total = 0, total_checks = 0;
   sdc_if link();
   sdc_controller i_sdc_controller (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req_i), .rcw_i(rcw_i),
      .desel_i(desel_i), .cke_i(cke_i), .bank_i(bank_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wmask_i(wmask_i), .wdata_en_i(wdata_en_i), .rdata_o(rdata_o), .link(link));
   sdc_device #(.MEM_DEPTH(256)) i_sdc_device (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(link),
      .last_op_o(last_op_o), .bank_open_o(bank_open_o), .powered_down_o(powered_down_o),
      .self_refresh_o(self_refresh_o), .burst_busy_o(burst_busy_o));
   sdc_props i_sdc_props (.clock_i(clock_i), .rst_n_i(rst_n_i), .cke(link.cke), .cs_n(link.cs_n),
      .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .bank_select(link.bank_select),
      .addr(link.addr), .dev_dq_oe(link.dev_dq_oe), .last_op_o(last_op_o), .bank_open_o(bank_open_o),
      .powered_down_o(powered_down_o), .self_refresh_o(self_refresh_o), .burst_busy_o(burst_busy_o));
   initial begin
      forever #4 clock_i = ~clock_i;
   end
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one command cycle, then the decoded operation is judged
   task automatic issue(input logic r, input logic [2:0] c, input logic d, input logic k,
                        input logic [2:0] b, input logic [12:0] a, input sdc_op_e op);
      @(posedge clock_i);
      req_i <= r; rcw_i <= c; desel_i <= d; cke_i <= k; bank_i <= b; addr_i <= a;
      @(posedge clock_i);
      req_i <= 1'b0;
      @(posedge clock_i);
      #1 check({12'h000, last_op_o}, {12'h000, op});
   endtask : issue
   task automatic wait_idle();
      int n;
      for (n = 0; n < 50 && burst_busy_o !== 1'b0; n++) begin
         // look once the edge has settled, not in its own time step
         @(posedge clock_i);
         #1;
      end
      if (n == 50) begin
         err_total++;
         wrap_up();
      end
   endtask : wait_idle
   // chopped write to bank 2 column 0, four beats with per-beat masks
   task automatic wr_chop(input logic [15:0] base, input logic [7:0] m);
      @(posedge clock_i);
      req_i <= 1'b1; rcw_i <= CMD_WR; bank_i <= 3'h2; addr_i <= 13'h0000;
      @(posedge clock_i);
      req_i <= 1'b0;
      wdata_en_i <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         wdata_i <= base + 16'(k);
         wmask_i <= m[2*k+:2];
         @(posedge clock_i);
      end
      wdata_en_i <= 1'b0;
      wait_idle();
   endtask : wr_chop
   task automatic rd_chop(input logic [63:0] exp);
      @(posedge clock_i);
      req_i <= 1'b1; rcw_i <= CMD_RD; bank_i <= 3'h2; addr_i <= 13'h0000;
      @(posedge clock_i);
      req_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      for (int k = 0; k < 4; k++) begin
         #1 check(rdata_o, exp[16*k+:16]);
         @(posedge clock_i);
      end
      wait_idle();
   endtask : rd_chop
   initial begin
      repeat (10) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      // on-the-fly burst length, sequential order, then long and short calibration
      issue(1, CMD_MRS, 0, 1, 3'h0, 13'h0001, SDC_OP_MRS);
      issue(1, CMD_ZQ, 0, 1, 3'h0, 13'h0400, SDC_OP_ZQL);
      issue(1, CMD_ZQ, 0, 1, 3'h0, 13'h0000, SDC_OP_ZQS);
      issue(1, CMD_REF, 0, 1, 3'h0, 13'h0000, SDC_OP_REF);
      issue(1, CMD_REF, 1, 1, 3'h0, 13'h0000, SDC_OP_NONE);
      issue(1, CMD_ACT, 0, 1, 3'h2, 13'h0005, SDC_OP_ACT);
      check(16'(bank_open_o), 16'h0004);
      wr_chop(16'h1110, 8'h00);
      wr_chop(16'h2220, 8'b11_10_01_00);
      rd_chop({16'h1113, 16'h1122, 16'h2211, 16'h2220});
      // eight-beat read with auto-close: the bank must close at the last beat
      issue(1, CMD_RD, 0, 1, 3'h2, 13'h1400, SDC_OP_RD);
      wait_idle();
      check(16'(bank_open_o), 16'h0000);
      issue(1, CMD_PRE, 0, 1, 3'h2, 13'h0000, SDC_OP_PRE);
      check(16'(bank_open_o), 16'h0000);
      issue(1, CMD_ACT, 0, 1, 3'h5, 13'h1fff, SDC_OP_ACT);
      issue(1, CMD_PRE, 0, 1, 3'h5, 13'h0400, SDC_OP_PREA);
      issue(0, CMD_NOP, 0, 0, 3'h0, 13'h0000, SDC_OP_PDE);
      check(16'(powered_down_o), 16'h0001);
      issue(1, CMD_NOP, 1, 1, 3'h0, 13'h0000, SDC_OP_PDX);
      check(16'(powered_down_o), 16'h0000);
      issue(1, CMD_REF, 0, 0, 3'h0, 13'h0000, SDC_OP_SRE);
      check(16'(self_refresh_o), 16'h0001);
      issue(0, CMD_NOP, 0, 1, 3'h0, 13'h0000, SDC_OP_PDX);
      check(16'(self_refresh_o), 16'h0000);
      // gate falling with an activate is undefined and must change nothing
      issue(1, CMD_ACT, 0, 0, 3'h1, 13'h0000, SDC_OP_ILL);
      check(16'(bank_open_o), 16'h0000);
      check(16'(powered_down_o), 16'h0000);
      wrap_up();
   end
endmodule : sdram_command_decode_tb_top
